// [rtl/fsmon_pkg.sv]
package fsmon_pkg;

   localparam int          DIV_RATIO     = 64;
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  OFS_CONFIG    = 8'h00;
   localparam logic [7:0]  OFS_OSCCTL    = 8'h04;
   localparam logic [7:0]  OFS_IRQFLG    = 8'h08;
   localparam logic [7:0]  OFS_IRQEN     = 8'h0C;
   localparam logic [7:0]  OFS_STATUS    = 8'h10;
   localparam logic [7:0]  OFS_CMD       = 8'h14;
   localparam int          CFG_MONEN_BIT = 0;
   localparam int          CFG_MODE_LSB  = 1;
   localparam int          OSC_SEL_LSB   = 0;
   localparam int          OSC_RUN_BIT   = 3;
   localparam int          IRQ_FAIL_BIT  = 7;
   localparam int          CMD_SLEEP_BIT = 0;
   localparam int          CMD_IDLE_BIT  = 1;
   localparam int          STS_STATE_LSB = 0;
   localparam int          STS_STATE_MSB = 2;
   localparam int          STS_INT_BIT   = 3;
   localparam int          STS_LATCH_BIT = 4;
   localparam int          STS_SCLK_BIT  = 5;
   localparam int          STS_MON_BIT   = 6;
   localparam logic [1:0]  SEL_PRIMARY   = 2'h0;
   localparam logic [1:0]  SEL_SECONDARY = 2'h1;
   localparam logic [1:0]  SEL_RST       = 2'h0;

   typedef enum logic [1:0] {
      MODE_EXT     = 2'h0,
      MODE_RC      = 2'h1,
      MODE_XTAL    = 2'h2,
      MODE_XTALPLL = 2'h3
   } fsmon_mode_type;

   typedef struct packed {
      fsmon_mode_type mode;
      logic           monEn;
   } fsmon_cfg_type;

   localparam fsmon_cfg_type CFG_RST = '{mode: MODE_XTAL, monEn: 1'b1};

   typedef enum logic [2:0] {
      ST_STARTUP,
      ST_RUN,
      ST_FAILSAFE,
      ST_POWERMGD,
      ST_SLEEP
   } fsmon_state_type;

   typedef struct packed {
      logic [ADDR_W-1:0]            paddr;
      logic [31:0]                  pwdata;
      logic                         psel;
      logic                         penable;
      logic                         pwrite;
   } fsmon_apb_req_type;

endpackage : fsmon_pkg

// [rtl/fsmon_sample_div.sv]
`timescale 1ns/1ns
module fsmon_sample_div #(
   parameter int DIV = fsmon_pkg::DIV_RATIO
) (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic clkEn,
   input  wire logic rcRun,
   input  wire logic rcClkIn,
   output logic      sampleClk,
   output logic      sampleRise,
   output logic      sampleFall
);
   localparam int                CW   = $clog2(DIV);
   localparam logic [CW-1:0]     HALF = CW'(DIV / 2 - 1);
   localparam logic [CW-1:0]     LAST = CW'(DIV - 1);

   logic          rcPrev_r;
   logic [CW-1:0] cnt_r;
   logic          rcRise;

   assign rcRise = rcRun & rcClkIn & ~rcPrev_r;

   // divide the internal rc clock by the ratio; msb is the sample clock
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rcPrev_r   <= 1'b0;
         cnt_r      <= '0;
         sampleClk  <= 1'b0;
         sampleRise <= 1'b0;
         sampleFall <= 1'b0;
      end else if (clkEn) begin
         rcPrev_r   <= rcClkIn;
         sampleRise <= rcRise && cnt_r == HALF;
         sampleFall <= rcRise && cnt_r == LAST;
         if (rcRise) begin
            cnt_r     <= cnt_r + 1'b1;
            sampleClk <= (cnt_r == HALF) ? 1'b1 : ((cnt_r == LAST) ? 1'b0 : sampleClk);
         end
      end
   end

   property p_div_period;
      @(posedge clk_sys) disable iff (sys_rst)
      sampleFall |-> cnt_r == '0 && !sampleClk;
   endproperty
   a_div_period: assert property (p_div_period) else $error("sample fall off the divide boundary");

endmodule : fsmon_sample_div

// [rtl/fsmon_core.sv]
`timescale 1ns/1ns
module fsmon_core (
   input  wire logic                         clk_sys,
   input  wire logic                         sys_rst,
   input  wire logic                         clkEn,
   input  wire logic                         devClkIn,
   input  wire logic                         rcClkIn,
   input  wire logic                         primaryReady,
   input  wire logic                         wakeEvent,
   input  wire logic                         irqPending,
   input  wire logic                         wdtOn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [fsmon_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   output logic                              useInternal,
   output logic                              primaryEnable,
   output logic                              rcOscEnable,
   output logic                              wdtClear,
   output logic                              cpuResume
);

   ////////////////////////////////////////////////////////////////////////////
   fsmon_pkg::fsmon_apb_req_type   req;
   fsmon_pkg::fsmon_cfg_type       cfg_r;
   fsmon_pkg::fsmon_state_type     state_r;
   fsmon_pkg::fsmon_state_type     state_nxt;
   logic [1:0]                     sel_r;
   logic                           primaryRunning_r;
   logic                           failFlag_r;
   logic                           failIrqEn_r;
   logic                           idleMode_r;
   logic                           latch_r;
   logic                           devPrev_r;
   logic                           devFall;
   logic                           sampleClk;
   logic                           sampleRise;
   logic                           sampleFall;
   logic                           monActive;
   logic                           failDetect;
   logic                           selInternal;
   logic                           mapped;
   logic                           wrEn;
   logic                           wrCmd;
   logic                           pmEntry;
   logic                           sleepCmd;
   logic                           xtalMode;

   assign req         = '{paddr: paddr, pwdata: pwdata, psel: psel, penable: penable, pwrite: pwrite};
   assign pready      = 1'b1;
   assign mapped      = req.paddr inside {fsmon_pkg::OFS_CONFIG, fsmon_pkg::OFS_OSCCTL, fsmon_pkg::OFS_IRQFLG,
                                          fsmon_pkg::OFS_IRQEN, fsmon_pkg::OFS_STATUS, fsmon_pkg::OFS_CMD};
   assign pslverr     = req.psel & req.penable & ~mapped;
   assign wrEn        = req.psel & req.penable & req.pwrite & mapped;
   assign wrCmd       = wrEn && req.paddr == fsmon_pkg::OFS_CMD;
   assign sleepCmd    = wrCmd & req.pwdata[fsmon_pkg::CMD_SLEEP_BIT];
   assign pmEntry     = wrCmd & (req.pwdata[fsmon_pkg::CMD_SLEEP_BIT] | req.pwdata[fsmon_pkg::CMD_IDLE_BIT]);
   assign xtalMode    = cfg_r.mode == fsmon_pkg::MODE_XTAL || cfg_r.mode == fsmon_pkg::MODE_XTALPLL;
   // both select codes above secondary name the internal block
   assign selInternal = sel_r != fsmon_pkg::SEL_PRIMARY && sel_r != fsmon_pkg::SEL_SECONDARY;

   ////////////////////////////////////////////////////////////////////////////
   // the watchdog's divider lives elsewhere; only its demand for rc is seen
   assign rcOscEnable = cfg_r.monEn | wdtOn;

   fsmon_sample_div #(
      .DIV (fsmon_pkg::DIV_RATIO)
   ) u_div (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .clkEn      (clkEn),
      .rcRun      (rcOscEnable),
      .rcClkIn    (rcClkIn),
      .sampleClk  (sampleClk),
      .sampleRise (sampleRise),
      .sampleFall (sampleFall)
   );

   // start-up intervals and internal source are never watched
   assign monActive  = cfg_r.monEn &&
                       (state_r == fsmon_pkg::ST_RUN ||
                        (state_r == fsmon_pkg::ST_POWERMGD && !selInternal));
   assign devFall    = devPrev_r & ~devClkIn;
   assign failDetect = monActive & sampleFall & latch_r;

   // a device edge in the same cycle as the clear keeps the latch set,
   // trading a possible false failure for no late detection
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         devPrev_r <= 1'b0;
         latch_r   <= 1'b0;
      end else if (clkEn) begin
         devPrev_r <= devClkIn;
         if (devFall) begin
            latch_r <= 1'b1;
         end else if (sampleRise) begin
            latch_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         fsmon_pkg::ST_STARTUP: begin
            if (pmEntry) begin
               state_nxt = sleepCmd ? fsmon_pkg::ST_SLEEP : fsmon_pkg::ST_POWERMGD;
            end else if (primaryReady || !xtalMode) begin
               state_nxt = fsmon_pkg::ST_RUN;
            end
         end
         fsmon_pkg::ST_RUN, fsmon_pkg::ST_POWERMGD: begin
            if (failDetect) begin
               state_nxt = fsmon_pkg::ST_FAILSAFE;
            end else if (pmEntry) begin
               state_nxt = sleepCmd ? fsmon_pkg::ST_SLEEP : fsmon_pkg::ST_POWERMGD;
            end
         end
         fsmon_pkg::ST_FAILSAFE: begin
            if (pmEntry) begin
               state_nxt = sleepCmd ? fsmon_pkg::ST_SLEEP : fsmon_pkg::ST_POWERMGD;
            end
         end
         fsmon_pkg::ST_SLEEP: begin
            if (wakeEvent) begin
               state_nxt = xtalMode ? fsmon_pkg::ST_STARTUP : fsmon_pkg::ST_RUN;
            end
         end
         default: begin
            state_nxt = fsmon_pkg::ST_STARTUP;
         end
      endcase
   end

   // external and rc modes need no start-up wait
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r <= fsmon_pkg::ST_STARTUP;
      end else if (clkEn) begin
         if (state_r == fsmon_pkg::ST_STARTUP && !xtalMode) begin
            state_r <= fsmon_pkg::ST_RUN;
         end else begin
            state_r <= state_nxt;
         end
      end
   end

   // clock mux and primary enable follow the state one cycle on
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         useInternal   <= 1'b1;
         primaryEnable <= 1'b1;
      end else if (clkEn) begin
         case (state_r)
            fsmon_pkg::ST_STARTUP: begin
               useInternal   <= 1'b1;
               primaryEnable <= 1'b1;
            end
            fsmon_pkg::ST_RUN: begin
               useInternal   <= 1'b0;
               primaryEnable <= 1'b1;
            end
            fsmon_pkg::ST_POWERMGD: begin
               useInternal   <= selInternal;
               primaryEnable <= sel_r == fsmon_pkg::SEL_PRIMARY;
            end
            fsmon_pkg::ST_FAILSAFE: begin
               useInternal   <= 1'b1;
               primaryEnable <= 1'b0;
            end
            default: begin
               useInternal   <= 1'b1;
               primaryEnable <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // the running bit is left alone in fail-safe so software sees the old source
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         primaryRunning_r <= 1'b0;
      end else if (clkEn) begin
         if (state_nxt == fsmon_pkg::ST_RUN && state_r != fsmon_pkg::ST_RUN) begin
            primaryRunning_r <= 1'b1;
         end else if (state_nxt == fsmon_pkg::ST_POWERMGD) begin
            primaryRunning_r <= sel_r == fsmon_pkg::SEL_PRIMARY;
         end else if (state_nxt == fsmon_pkg::ST_STARTUP || state_nxt == fsmon_pkg::ST_SLEEP) begin
            primaryRunning_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         failFlag_r <= 1'b0;
      end else if (clkEn) begin
         if (failDetect) begin
            failFlag_r <= 1'b1;
         end else if (wrEn && req.paddr == fsmon_pkg::OFS_IRQFLG) begin
            failFlag_r <= req.pwdata[fsmon_pkg::IRQ_FAIL_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wdtClear <= 1'b0;
      end else if (clkEn) begin
         wdtClear <= failDetect;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         idleMode_r <= 1'b0;
         cpuResume  <= 1'b0;
      end else if (clkEn) begin
         cpuResume <= idleMode_r && irqPending && state_r == fsmon_pkg::ST_FAILSAFE && !failIrqEn_r;
         if (pmEntry) begin
            idleMode_r <= ~req.pwdata[fsmon_pkg::CMD_SLEEP_BIT];
         end else if (irqPending) begin
            idleMode_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cfg_r       <= fsmon_pkg::CFG_RST;
         sel_r       <= fsmon_pkg::SEL_RST;
         failIrqEn_r <= 1'b0;
      end else if (clkEn && wrEn) begin
         case (req.paddr)
            fsmon_pkg::OFS_CONFIG: begin
               cfg_r <= req.pwdata[fsmon_pkg::CFG_MODE_LSB+1:fsmon_pkg::CFG_MONEN_BIT];
            end
            fsmon_pkg::OFS_OSCCTL: begin
               sel_r <= req.pwdata[fsmon_pkg::OSC_SEL_LSB+1:fsmon_pkg::OSC_SEL_LSB];
            end
            fsmon_pkg::OFS_IRQEN: begin
               failIrqEn_r <= req.pwdata[fsmon_pkg::IRQ_FAIL_BIT];
            end
            default: begin
               failIrqEn_r <= failIrqEn_r;
            end
         endcase
      end
   end

   // read data is caught in the setup cycle and stands through access
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (clkEn && req.psel && !req.penable) begin
         prdata <= 32'h0000_0000;
         case (req.paddr)
            fsmon_pkg::OFS_CONFIG: begin
               prdata[fsmon_pkg::CFG_MODE_LSB+1:fsmon_pkg::CFG_MONEN_BIT] <= cfg_r;
            end
            fsmon_pkg::OFS_OSCCTL: begin
               prdata[fsmon_pkg::OSC_SEL_LSB+1:fsmon_pkg::OSC_SEL_LSB] <= sel_r;
               prdata[fsmon_pkg::OSC_RUN_BIT]                          <= primaryRunning_r;
            end
            fsmon_pkg::OFS_IRQFLG: begin
               prdata[fsmon_pkg::IRQ_FAIL_BIT] <= failFlag_r;
            end
            fsmon_pkg::OFS_IRQEN: begin
               prdata[fsmon_pkg::IRQ_FAIL_BIT] <= failIrqEn_r;
            end
            fsmon_pkg::OFS_STATUS: begin
               prdata[fsmon_pkg::STS_STATE_MSB:fsmon_pkg::STS_STATE_LSB] <= state_r;
               prdata[fsmon_pkg::STS_INT_BIT]                            <= useInternal;
               prdata[fsmon_pkg::STS_LATCH_BIT]                          <= latch_r;
               prdata[fsmon_pkg::STS_SCLK_BIT]                           <= sampleClk;
               prdata[fsmon_pkg::STS_MON_BIT]                            <= monActive;
            end
            default: begin
               prdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   property p_mon_enable;
      !cfg_r.monEn |-> !monActive && !failDetect;
   endproperty
   a_mon_enable: assert property (p_mon_enable) else $error("monitor active while disabled");

   property p_rc_on;
      cfg_r.monEn |-> rcOscEnable;
   endproperty
   a_rc_on: assert property (p_rc_on) else $error("rc stopped while monitoring enabled");

   property p_latch_set;
      clkEn && devFall |=> latch_r;
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("latch not set on device fall");

   property p_fail_state;
      clkEn && monActive && sampleFall && latch_r |=> state_r == fsmon_pkg::ST_FAILSAFE ##1 useInternal;
   endproperty
   a_fail_state: assert property (p_fail_state) else $error("failure did not switch clock");

   property p_fail_flag;
      clkEn && failDetect |=> failFlag_r && wdtClear;
   endproperty
   a_fail_flag: assert property (p_fail_flag) else $error("failure without flag or watchdog clear");

   property p_no_internal_mon;
      state_r == fsmon_pkg::ST_POWERMGD && selInternal |-> !monActive;
   endproperty
   a_no_internal_mon: assert property (p_no_internal_mon) else $error("internal source monitored");

   property p_stay_failsafe;
      clkEn && state_r == fsmon_pkg::ST_FAILSAFE && !pmEntry |=> state_r == fsmon_pkg::ST_FAILSAFE;
   endproperty
   a_stay_failsafe: assert property (p_stay_failsafe) else $error("fail-safe left without cause");

   property p_osc_frozen;
      clkEn && state_r == fsmon_pkg::ST_FAILSAFE && !pmEntry |=> $stable(primaryRunning_r);
   endproperty
   a_osc_frozen: assert property (p_osc_frozen) else $error("control updated in fail-safe");

   property p_startup_quiet;
      state_r == fsmon_pkg::ST_STARTUP |-> !monActive && !failFlag_r || $past(failFlag_r);
   endproperty
   a_startup_quiet: assert property (p_startup_quiet) else $error("flag raised during start-up");

   property p_pm_primary_off;
      clkEn && state_r == fsmon_pkg::ST_STARTUP && pmEntry && sel_r != fsmon_pkg::SEL_PRIMARY
         |=> ##1 !primaryEnable;
   endproperty
   a_pm_primary_off: assert property (p_pm_primary_off) else $error("primary left on at new mode");

   c_failure:  cover property (failDetect);
   c_ready:    cover property (state_r == fsmon_pkg::ST_STARTUP ##1 state_r == fsmon_pkg::ST_RUN);
   c_fs_exit:  cover property (state_r == fsmon_pkg::ST_FAILSAFE ##1 state_r == fsmon_pkg::ST_POWERMGD);
   c_resume:   cover property (cpuResume);

endmodule : fsmon_core

// [dv/fsmon_tb.sv]
`timescale 1ns/1ns
module fsmon_tb;
   logic                         clk_sys;
   logic                         sys_rst;
   logic                         clkEn;
   logic                         devClkIn;
   logic                         rcClkIn;
   logic                         primaryReady;
   logic                         wakeEvent;
   logic                         irqPending;
   logic                         wdtOn;
   logic                         psel;
   logic                         penable;
   logic                         pwrite;
   logic [fsmon_pkg::ADDR_W-1:0] paddr;
   logic [31:0]                  pwdata;
   logic [31:0]                  prdata;
   logic                         pready;
   logic                         pslverr;
   logic                         useInternal;
   logic                         primaryEnable;
   logic                         rcOscEnable;
   logic                         wdtClear;
   logic                         cpuResume;
   logic                         devRun;
   logic [31:0]                  rdv;
   logic                         errv;
   logic                         hit;
   logic                         resumeHit;
   int                           fails;
   int                           samplesChecked;

   fsmon_core fsmon_core_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .devClkIn(devClkIn), .rcClkIn(rcClkIn),
      .primaryReady(primaryReady), .wakeEvent(wakeEvent), .irqPending(irqPending), .wdtOn(wdtOn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .useInternal(useInternal), .primaryEnable(primaryEnable),
      .rcOscEnable(rcOscEnable), .wdtClear(wdtClear), .cpuResume(cpuResume)
   );

   ////////////////////////////////////////////////////////////////////////////////
   always #2 clk_sys = ~clk_sys;

   // rc toggles every cycle, so one sample period is 128 system cycles
   always @(posedge clk_sys) begin
      rcClkIn <= ~rcClkIn;
      if (devRun) begin
         devClkIn <= ~devClkIn;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // entered just after a rising edge; holds the request until pready is sampled
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         test_done();
      end
      rdv = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : xfer

   task automatic chkReg(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
      xfer(a, 1'b0, 32'h0);
      chk(name, rdv & mask, exp);
   endtask : chkReg

   // a pulse only lives one cycle, so every cycle is looked at mid-period
   task automatic watch(input int n);
      hit = 1'b0;
      resumeHit = 1'b0;
      repeat (n) begin
         @(negedge clk_sys);
         if (wdtClear === 1'b1) hit = 1'b1;
         if (cpuResume === 1'b1) resumeHit = 1'b1;
      end
      @(posedge clk_sys);
   endtask : watch

   task automatic rst();
      sys_rst <= 1'b1;
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
   endtask : rst

   task automatic wake();
      wakeEvent <= 1'b1;
      @(posedge clk_sys);
      wakeEvent <= 1'b0;
      @(posedge clk_sys);
   endtask : wake

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      test_done();
   end

   initial begin
      clk_sys = 1'b0; sys_rst = 1'b1; clkEn = 1'b1; devClkIn = 1'b1; rcClkIn = 1'b0; primaryReady = 1'b0;
      wakeEvent = 1'b0; irqPending = 1'b0; wdtOn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; devRun = 1'b0; fails = 0; samplesChecked = 0;
      @(posedge clk_sys);
      rst();
      chkReg("config", fsmon_pkg::OFS_CONFIG, 32'h5, 32'h7);
      chkReg("oscctl", fsmon_pkg::OFS_OSCCTL, 32'h0, 32'hB);
      chkReg("irqflg", fsmon_pkg::OFS_IRQFLG, 32'h0, 32'h80);
      xfer(8'h20, 1'b0, 32'h0);
      chk("unmappedData", rdv, 32'h0);
      chk("unmappedErr", {31'h0, errv}, 32'h1);
      // crystal mode, primary never ready, device clock dead
      watch(400);
      chk("noStartFail", {31'h0, hit}, 32'h0);
      chkReg("statusStart", fsmon_pkg::OFS_STATUS, 32'h8, 32'hF);
      xfer(fsmon_pkg::OFS_OSCCTL, 1'b1, 32'h1);
      chkReg("selStart", fsmon_pkg::OFS_OSCCTL, 32'h1, 32'hB);
      xfer(fsmon_pkg::OFS_CMD, 1'b1, 32'h1);
      chkReg("statusSleep", fsmon_pkg::OFS_STATUS, 32'h4, 32'h7);
      chk("primaryEnable", {31'h0, primaryEnable}, 32'h0);
      xfer(fsmon_pkg::OFS_OSCCTL, 1'b1, 32'h0);
      xfer(fsmon_pkg::OFS_CONFIG, 1'b1, 32'h1);
      wake();
      chkReg("statusRun", fsmon_pkg::OFS_STATUS, 32'h1, 32'h7);
      // device falls keep the latch set up to the sample fall, which trips it
      devRun <= 1'b1;
      watch(400);
      chk("failDetect", {31'h0, hit}, 32'h1);
      chkReg("failFlag", fsmon_pkg::OFS_IRQFLG, 32'h80, 32'h80);
      chk("useInternalFail", {31'h0, useInternal}, 32'h1);
      chkReg("oscctlFail", fsmon_pkg::OFS_OSCCTL, 32'h8, 32'hB);
      xfer(fsmon_pkg::OFS_IRQFLG, 1'b1, 32'h0);
      chkReg("flagClear", fsmon_pkg::OFS_IRQFLG, 32'h0, 32'h80);
      // a quiet device clock lets the sample rise leave the latch clear
      devRun <= 1'b0;
      watch(300);
      chkReg("stayFailsafe", fsmon_pkg::OFS_STATUS, 32'h2, 32'h7);
      xfer(fsmon_pkg::OFS_CMD, 1'b1, 32'h2);
      chkReg("statusPm", fsmon_pkg::OFS_STATUS, 32'h3, 32'h7);
      watch(400);
      chk("healthyClock", {31'h0, hit}, 32'h0);
      chk("useInternalPm", {31'h0, useInternal}, 32'h0);
      clkEn <= 1'b0;
      devRun <= 1'b1;
      watch(400);
      chk("frozenNoFail", {31'h0, hit}, 32'h0);
      clkEn <= 1'b1;
      watch(400);
      chk("pmFail", {31'h0, hit}, 32'h1);
      // interrupt only after the failure, so idle is still pending
      irqPending <= 1'b1;
      watch(4);
      chk("cpuResume", {31'h0, resumeHit}, 32'h1);
      chkReg("statusPmFail", fsmon_pkg::OFS_STATUS, 32'hA, 32'hF);
      irqPending <= 1'b0;
      // monitor switched off, rc mode: a tripping device clock goes unnoticed
      rst();
      xfer(fsmon_pkg::OFS_CONFIG, 1'b1, 32'h2);
      chkReg("oscctlRc", fsmon_pkg::OFS_OSCCTL, 32'h8, 32'hB);
      xfer(fsmon_pkg::OFS_CMD, 1'b1, 32'h1);
      wake();
      watch(400);
      chk("monitorOff", {31'h0, hit}, 32'h0);
      @(negedge clk_sys);
      chk("rcOffIdle", {31'h0, rcOscEnable}, 32'h0);
      @(posedge clk_sys);
      wdtOn <= 1'b1;
      @(negedge clk_sys);
      chk("rcWatchdog", {31'h0, rcOscEnable}, 32'h1);
      @(posedge clk_sys);
      // crystal with pll comes ready, then internal select in power-managed mode
      rst();
      xfer(fsmon_pkg::OFS_CONFIG, 1'b1, 32'h7);
      primaryReady <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chkReg("oscctlRun", fsmon_pkg::OFS_OSCCTL, 32'h8, 32'hB);
      chk("useInternalRun", {31'h0, useInternal}, 32'h0);
      xfer(fsmon_pkg::OFS_OSCCTL, 1'b1, 32'h2);
      xfer(fsmon_pkg::OFS_CMD, 1'b1, 32'h2);
      watch(400);
      chk("internalNotWatched", {31'h0, hit}, 32'h0);
      test_done();
   end
endmodule : fsmon_tb
